// [pkg/csl_consts.svh]
// constants for the csr write port and led stretcher
`ifndef CSL_CONSTS_SVH
`define CSL_CONSTS_SVH
`define CSL_ADDR_W 6
`define CSL_DATA_W 32
`define CSL_STRB_W 4
`define CSL_NUM_REGS 8
`define CSL_REG_LAST 6'h1C
`define CSL_REG_RESET 32'h0000_0000
`define CSL_LED_SRC_INIT 3'h0
`define CSL_LED_STRETCH_INIT 16'h0000
`define CSL_REFCLK_MHZ 200
`define CSL_CLK_MHZ 25
`endif

// [pkg/csl_pkg.sv]
// types for the csr write port and led stretcher
package csl_pkg;
   typedef enum logic [1:0] {
      CSL_RESP_OKAY = 2'h0,
      CSL_RESP_EXOKAY = 2'h1,
      CSL_RESP_SLVERR = 2'h2,
      CSL_RESP_DECERR = 2'h3
   } csl_resp_t;
   typedef enum logic [2:0] {
      CSL_LED_OFF = 3'h0,
      CSL_LED_SEL_GATE = 3'h1,
      CSL_LED_SEL_SYNC = 3'h2,
      CSL_LED_SEL_PPS = 3'h3,
      CSL_LED_OUT_GATE = 3'h4,
      CSL_LED_OUT_SYNC = 3'h5,
      CSL_LED_USER_PPS = 3'h6
   } csl_led_src_t;
   typedef enum logic [2:0] {
      CSL_W_IDLE = 3'b001,
      CSL_W_HAVE_ADDR = 3'b010,
      CSL_W_RESP = 3'b100
   } csl_wstate_t;
   typedef struct packed {
      logic sel_gate;
      logic sel_sync;
      logic sel_pps;
      logic out_gate;
      logic out_sync;
      logic user_pps;
   } csl_events_t;
endpackage

// [verification/csl_csr_chk.sv]
// assertions for the csr port
`timescale 1ns/10ps
module csl_csr_chk (
   input wire logic clk, srst, aresetn, awvalid, awready, wvalid,
   input wire logic wready, bvalid, bready, arvalid, arready, rvalid, rready,
   input wire csl_pkg::csl_resp_t bresp
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst || !aresetn);
   sequence s_aw_only; awvalid && awready && !wvalid; endsequence
   property p_split; s_aw_only |=> !awready && wready; endproperty
   a_split: assert property (p_split) else $error("split");
   property p_b_rise; wvalid && wready |=> bvalid; endproperty
   a_b_rise: assert property (p_b_rise) else $error("b rise");
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("b hold");
   property p_b_done; bvalid && bready |=> !bvalid && awready; endproperty
   a_b_done: assert property (p_b_done) else $error("b done");
   property p_b_busy; bvalid |-> !awready && !wready; endproperty
   a_b_busy: assert property (p_b_busy) else $error("b busy");
   property p_r_rise; arvalid && arready |=> rvalid; endproperty
   a_r_rise: assert property (p_r_rise) else $error("r rise");
   property p_r_hold; rvalid && !rready |=> rvalid; endproperty
   a_r_hold: assert property (p_r_hold) else $error("r hold");
   property p_r_busy; rvalid |-> !arready; endproperty
   a_r_busy: assert property (p_r_busy) else $error("r busy");
endmodule
bind csl_csr csl_csr_chk csl_csr_chk_i (.*);

// [verification/csl_csr_tb.sv]
// bench for the csr port and led stretcher
`timescale 1ns/10ps
module csl_csr_tb;
   import csl_pkg::*;
   localparam logic [15:0] STR = 16'h0003;
   logic clk = 1'h0, srst = 1'h1, aresetn = 1'h1;
   logic awvalid, awready, wvalid, wready, bvalid, bready, led, arvalid;
   logic arready, rvalid, rready;
   logic [5:0] awaddr, araddr;
   logic [2:0] awprot, arprot, led_src;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [15:0] refclk_mhz;
   csl_resp_t bresp, rresp, r;
   csl_events_t events = '0;
   int n_errors = 0, compares = 0;
   always #20 clk = ~clk;
   csl_csr #(.LED_STRETCH(STR)) csl_csr_i (.*);
   csl_mst csl_mst_i (.*);
   task automatic chk(string n, logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic t_wr;
      chk("src0", CSL_LED_OFF, led_src);
      csl_mst_i.wr(6'h04, 4'hF, 32'h1234_5678, 1'h0, 0, r);
      chk("ok", CSL_RESP_OKAY, r);
      csl_mst_i.wr(6'h04, 4'h5, 32'hAABB_CCDD, 1'h1, 2, r);
      csl_mst_i.rd(6'h04, d, r);
      chk("strb", 32'h12BB_56DD, d);
      chk("rok", CSL_RESP_OKAY, r);
      csl_mst_i.wr(6'h20, 4'hF, 32'h0000_0001, 1'h0, 0, r);
      chk("dec", CSL_RESP_DECERR, r);
      csl_mst_i.wr(6'h06, 4'hF, 32'h0000_0002, 1'h0, 0, r);
      chk("unaligned", CSL_RESP_DECERR, r);
      csl_mst_i.rd(6'h04, d, r);
      chk("kept", 32'h12BB_56DD, d);
      csl_mst_i.rd(6'h22, d, r);
      chk("rdec", CSL_RESP_DECERR, r);
      chk("rdzero", 32'h0000_0000, d);
   endtask
   task automatic t_led;
      int n;
      csl_mst_i.wr(6'h00, 4'h1, 32'h0000_0006, 1'h0, 0, r);
      for (int k = 0; k < 2; k++) begin
         events <= k ? 6'h20 : 6'h01;
         @(posedge clk);
         events <= '0;
         n = 0;
         repeat (8) @(posedge clk) n += led;
         chk("led", k ? 0 : STR + 1, n);
      end
   endtask
   task automatic t_rst;
      aresetn <= 1'h0;
      @(posedge clk);
      aresetn <= 1'h1;
      @(posedge clk);
      chk("src", CSL_LED_OFF, led_src);
      chk("mhz", 16'h00C8, refclk_mhz);
      csl_mst_i.rd(6'h04, d, r);
      chk("rstreg", 32'h0000_0000, d);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'h0;
      t_wr();
      t_led();
      t_rst();
      end_of_test();
   end
   // each scenario needs well under a hundred cycles
   initial begin
      repeat (2000) @(posedge clk);
      n_errors++;
      end_of_test();
   end
endmodule

// [verification/csl_mst.sv]
// bus master model for the csr port
`timescale 1ns/10ps
module csl_mst (
   input wire logic clk, awready, wready, bvalid, arready, rvalid,
   input wire csl_pkg::csl_resp_t bresp, rresp,
   input wire logic [31:0] rdata,
   output logic [5:0] awaddr = '0, araddr = '0,
   output logic [2:0] awprot = '0, arprot = '0,
   output logic [31:0] wdata = '0,
   output logic [3:0] wstrb = '0,
   output logic awvalid = '0, wvalid = '0, bready = '0,
   output logic arvalid = '0, rready = '0
);
   import csl_pkg::*;
   // released address and data lines show the inverse so stale values are never trusted
   task automatic wr(logic [5:0] a, logic [3:0] s, logic [31:0] d,
      bit split, int slow, output csl_resp_t r);
      @(posedge clk);
      {awaddr, awprot, awvalid} <= {a, ~a[2:0], 1'h1};
      {wdata, wstrb, wvalid} <= {d, s, !split};
      do @(posedge clk); while (!awready);
      {awaddr, awvalid} <= {~a, 1'h0};
      if (split) begin
         wvalid <= 1'h1;
         do @(posedge clk); while (!wready);
      end
      {wdata, wvalid} <= {~d, 1'h0};
      repeat (slow) @(posedge clk);
      bready <= 1'h1;
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(logic [5:0] a, output logic [31:0] d,
      output csl_resp_t rr);
      @(posedge clk);
      {araddr, arprot, arvalid} <= {a, a[2:0], 1'h1};
      do @(posedge clk); while (!arready);
      {araddr, arvalid} <= {~a, 1'h0};
      @(posedge clk);
      rready <= 1'h1;
      do @(posedge clk); while (!rvalid);
      d = rdata;
      rr = rresp;
      rready <= 1'h0;
   endtask
endmodule

// [verilog/csl_csr.sv]
// csr write/read slave port with activity led stretcher
`timescale 1ns/10ps
`include "csl_consts.svh"

module csl_csr #(
   parameter logic [2:0] INIT_LED_SRC = `CSL_LED_SRC_INIT,
   parameter logic [15:0] LED_STRETCH = `CSL_LED_STRETCH_INIT,
   parameter int REFCLK_MHZ = `CSL_REFCLK_MHZ
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   input wire logic aresetn,
   // write address channel
   input wire logic [`CSL_ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // write data channel
   input wire logic [`CSL_DATA_W-1:0] wdata,
   input wire logic [`CSL_STRB_W-1:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // write response channel
   output csl_pkg::csl_resp_t bresp,
   output logic bvalid,
   input wire logic bready,
   // read channels
   input wire logic [`CSL_ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [`CSL_DATA_W-1:0] rdata,
   output csl_pkg::csl_resp_t rresp,
   output logic rvalid,
   input wire logic rready,
   // led events and drive
   input wire csl_pkg::csl_events_t events,
   output logic led,
   output logic [2:0] led_src,
   output logic [15:0] refclk_mhz
);
   import csl_pkg::*;

   // reset and ignored inputs
   logic rst;
   logic unused_prot;

   // write channel
   csl_wstate_t wstate;
   logic [`CSL_ADDR_W-1:0] waddr_q;
   logic [`CSL_ADDR_W-1:0] eff_waddr;
   // write handshake qualifiers
   logic addr_take;
   logic data_take;
   logic resp_take;
   logic wfire;
   logic wdec_ok;
   logic [2:0] widx;
   logic [`CSL_NUM_REGS-1:0] wsel;
   logic [`CSL_STRB_W-1:0] byte_en;

   // register storage, eight words
   logic [`CSL_DATA_W-1:0] regs [`CSL_NUM_REGS];

   // read channel
   logic rfire;
   logic rdec_ok;
   logic [2:0] ridx;
   logic [`CSL_DATA_W-1:0] rword;

   // led path
   logic pulse;
   logic [15:0] stretch_cnt;
   logic stretch_busy;

   // both resets reinit the registers
   // srst and the bus reset are both synchronous
   assign rst = srst | ~aresetn;

   // protection bits are folded away and never steer an access
   assign unused_prot = ^{awprot, arprot};

   // figure passed through for the tap-delay logic
   assign refclk_mhz = 16'(REFCLK_MHZ);

   // address may come with the data or earlier
   assign awready = (wstate == CSL_W_IDLE);
   assign wready = (wstate == CSL_W_HAVE_ADDR) ||
                   ((wstate == CSL_W_IDLE) && awvalid);
   assign addr_take = awvalid && awready;
   assign data_take = wvalid && wready;
   assign resp_take = bvalid && bready;
   // the store, the flag and the code all key off the data beat
   assign wfire = data_take;
   assign eff_waddr = (wstate == CSL_W_IDLE) ? awaddr : waddr_q;
   assign widx = eff_waddr[4:2];

   // unaligned or above 0x1C answers decode error
   assign wdec_ok = (eff_waddr[1:0] == 2'h0) &&
                    (eff_waddr <= `CSL_REG_LAST);

   // state only; the address latch has its own process below
   always_ff @(posedge clk) begin
      if (rst) begin
         wstate <= CSL_W_IDLE;
      end else begin
         case (wstate)
            CSL_W_IDLE: begin
               // address and data together skip the wait
               if (addr_take) begin
                  if (data_take) begin
                     wstate <= CSL_W_RESP;
                  end else begin
                     wstate <= CSL_W_HAVE_ADDR;
                  end
               end
            end
            CSL_W_HAVE_ADDR: begin
               // address held, waiting for the data beat
               if (data_take) begin
                  wstate <= CSL_W_RESP;
               end
            end
            CSL_W_RESP: begin
               // no new address until the answer is taken
               if (resp_take) begin
                  wstate <= CSL_W_IDLE;
               end
            end
            default: begin
               // a lost one-hot code falls back to idle
               wstate <= CSL_W_IDLE;
            end
         endcase
      end
   end

   // address latch, loaded only on the address handshake
   // held through the data wait and unused after it
   always_ff @(posedge clk) begin
      if (rst) begin
         waddr_q <= '0;
      end else if (addr_take) begin
         waddr_q <= awaddr;
      end
   end

   // no new write is taken while the response stands
   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid <= 1'b0;
      end else if (wfire) begin
         bvalid <= 1'b1;
      end else if (resp_take) begin
         bvalid <= 1'b0;
      end
   end

   // code set with the flag, held with it
   // decode error leaves every register alone
   always_ff @(posedge clk) begin
      if (rst) begin
         bresp <= CSL_RESP_OKAY;
      end else if (wfire) begin
         if (wdec_ok) begin
            bresp <= CSL_RESP_OKAY;
         end else begin
            bresp <= CSL_RESP_DECERR;
         end
      end
   end

   // byte lanes follow the strobes, bit 0 the lowest byte
   assign byte_en = wstrb;

   // one select and one word per register; word 0 holds the led source
   genvar gi;
   generate
      for (gi = 0; gi < `CSL_NUM_REGS; gi++) begin : g_reg
         assign wsel[gi] = wfire && wdec_ok && (widx == 3'(gi));
         always_ff @(posedge clk) begin
            if (rst) begin
               if (gi == 0) begin
                  regs[gi] <= {29'h000_0000, INIT_LED_SRC};
               end else begin
                  regs[gi] <= `CSL_REG_RESET;
               end
            end else if (wsel[gi]) begin
               // strobed bytes only; the rest keep their old value
               for (int b = 0; b < `CSL_STRB_W; b++) begin
                  if (byte_en[b]) begin
                     regs[gi][b*8 +: 8] <= wdata[b*8 +: 8];
                  end
               end
            end
         end
      end
   endgenerate

   // selector is the low three bits of word 0
   assign led_src = regs[0][2:0];

   // read side: one outstanding read, next address waits for rready
   // the read path never changes a register
   assign arready = ~rvalid;
   assign rfire = arvalid && arready;
   assign ridx = araddr[4:2];
   assign rdec_ok = (araddr[1:0] == 2'h0) &&
                    (araddr <= `CSL_REG_LAST);

   // word picked here, captured only on the handshake
   always_comb begin
      rword = '0;
      for (int i = 0; i < `CSL_NUM_REGS; i++) begin
         if (ridx == 3'(i)) begin
            rword = regs[i];
         end
      end
   end

   // flag drops on the edge where rready is seen
   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid <= 1'b0;
      end else if (rfire) begin
         rvalid <= 1'b1;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // data and code stay put while rvalid stands
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= '0;
         rresp <= CSL_RESP_OKAY;
      end else if (rfire) begin
         if (rdec_ok) begin
            rdata <= rword;
            rresp <= CSL_RESP_OKAY;
         end else begin
            rdata <= '0;
            rresp <= CSL_RESP_DECERR;
         end
      end
   end

   // events are taken as already synchronous to clk
   // led source mux; codes 7 and 0 show nothing
   always_comb begin
      case (led_src)
         CSL_LED_SEL_GATE: pulse = events.sel_gate;
         CSL_LED_SEL_SYNC: pulse = events.sel_sync;
         CSL_LED_SEL_PPS: pulse = events.sel_pps;
         CSL_LED_OUT_GATE: pulse = events.out_gate;
         CSL_LED_OUT_SYNC: pulse = events.out_sync;
         CSL_LED_USER_PPS: pulse = events.user_pps;
         default: pulse = 1'b0;
      endcase
   end

   // stretch restarts on every pulse, so a burst looks like one long on
   always_ff @(posedge clk) begin
      if (rst) begin
         stretch_cnt <= '0;
      end else if (pulse) begin
         stretch_cnt <= LED_STRETCH;
      end else if (stretch_busy) begin
         stretch_cnt <= stretch_cnt - 16'h0001;
      end
   end

   // count of zero means the led goes dark next edge
   assign stretch_busy = (stretch_cnt != 16'h0000);

   // led is a flop so the pin never glitches on the mux
   // a zero stretch still gives one cycle of light
   always_ff @(posedge clk) begin
      if (rst) begin
         led <= 1'b0;
      end else begin
         led <= pulse || stretch_busy;
      end
   end
endmodule
